/* common/drac_pkg.sv */
package drac_pkg;
    localparam int BUF_BYTES        = 2097152;
    localparam int SECTOR_BYTES     = 512;
    localparam int BUF_SECTORS      = BUF_BYTES / SECTOR_BYTES;
    localparam int PTR_W            = $clog2(BUF_SECTORS);
    localparam int WORK_SECTORS_DEF = 512;
    localparam int RA_SECTORS_DEF   = 256;
    localparam int LBA_W            = 28;
    localparam int CNT_W            = 9;

    typedef logic [LBA_W-1:0] drac_lba_t;
    typedef logic [PTR_W-1:0] drac_ptr_t;
    typedef logic [PTR_W:0]   drac_cnt_t;

    localparam drac_lba_t RST_LBA = 28'h0000000;
    localparam drac_cnt_t RST_CNT = 13'h0000;

    typedef enum logic [1:0] {
        DRAC_CMD_READ   = 2'h0,
        DRAC_CMD_WRITE  = 2'h1,
        DRAC_CMD_CHKPWR = 2'h2,
        DRAC_CMD_OTHER  = 2'h3
    } drac_kind_t;

    typedef struct packed {
        drac_kind_t           kind;
        drac_lba_t            lba;
        logic [CNT_W-1:0]     count;
    } drac_cmd_t;

    typedef struct packed {
        drac_lba_t lba;
        drac_ptr_t ptr;
    } drac_loc_t;

    typedef enum logic [4:0] {
        DRAC_CL_MISS     = 5'h01,
        DRAC_CL_SEQ_MISS = 5'h02,
        DRAC_CL_PARTIAL  = 5'h04,
        DRAC_CL_SEQ_HIT  = 5'h08,
        DRAC_CL_FULL     = 5'h10
    } drac_class_t;

    typedef enum logic [1:0] {
        DRAC_ST_IDLE = 2'h1,
        DRAC_ST_XFER = 2'h2
    } drac_state_t;
endpackage

/* core/drac_classify.sv */
`timescale 1ns/1ps
module drac_classify (
    input  drac_pkg::drac_cmd_t   i_cmd,
    input  drac_pkg::drac_lba_t   i_valid_lo,
    input  drac_pkg::drac_cnt_t   i_valid_cnt,
    input  drac_pkg::drac_lba_t   i_prev_end,
    input  logic                  i_prev_ok,
    input  logic                  i_cache_en,
    output drac_pkg::drac_class_t o_class
);
    logic [drac_pkg::LBA_W:0] vend;
    logic [drac_pkg::LBA_W:0] rend;
    logic                     lead_hit;
    logic                     all_hit;
    logic                     seq;

    // Range compare against cached window
    assign vend     = {1'b0, i_valid_lo} + {{(drac_pkg::LBA_W - drac_pkg::PTR_W){1'b0}}, i_valid_cnt};
    assign rend     = {1'b0, i_cmd.lba} + {{(drac_pkg::LBA_W + 1 - drac_pkg::CNT_W){1'b0}}, i_cmd.count};
    assign lead_hit = i_cache_en && (i_valid_cnt != '0) && (i_cmd.lba >= i_valid_lo)
                      && ({1'b0, i_cmd.lba} < vend);
    assign all_hit  = lead_hit && (rend <= vend);
    assign seq      = i_prev_ok && (i_cmd.lba == i_prev_end);

    always_comb
    begin
        if (all_hit)
            o_class = drac_pkg::DRAC_CL_FULL;
        else if (lead_hit && seq)
            o_class = drac_pkg::DRAC_CL_SEQ_HIT;
        else if (lead_hit)
            o_class = drac_pkg::DRAC_CL_PARTIAL;
        else if (seq)
            o_class = drac_pkg::DRAC_CL_SEQ_MISS;
        else
            o_class = drac_pkg::DRAC_CL_MISS;
    end
endmodule

/* core/drac_cache.sv */
`timescale 1ns/1ps
module drac_cache #(
    parameter int WORK_SECTORS = drac_pkg::WORK_SECTORS_DEF,
    parameter int RA_SECTORS   = drac_pkg::RA_SECTORS_DEF
) (
    input  logic                  i_clk,
    input  logic                  i_rst,
    input  logic                  i_ce,
    input  logic                  i_cmd_valid,
    input  drac_pkg::drac_cmd_t   i_cmd,
    output logic                  o_cmd_ready,
    input  logic                  i_cache_en,
    input  logic                  i_soft_reset,
    input  logic                  i_cmd_error,
    output logic                  o_med_req,
    output drac_pkg::drac_loc_t   o_med,
    input  logic                  i_med_done,
    output logic                  o_host_ready,
    output drac_pkg::drac_loc_t   o_host,
    input  logic                  i_host_done,
    output logic                  o_xfer_done,
    output drac_pkg::drac_class_t o_class,
    output drac_pkg::drac_cnt_t   o_cached_cnt
);
    localparam int                  CAP       = drac_pkg::BUF_SECTORS - WORK_SECTORS;
    localparam drac_pkg::drac_cnt_t CAP_CNT   = drac_pkg::drac_cnt_t'(CAP);
    localparam drac_pkg::drac_cnt_t RA_CNT    = drac_pkg::drac_cnt_t'(RA_SECTORS);
    localparam drac_pkg::drac_ptr_t FIRST_PTR = drac_pkg::drac_ptr_t'(WORK_SECTORS);
    localparam drac_pkg::drac_ptr_t LAST_PTR  = drac_pkg::drac_ptr_t'(drac_pkg::BUF_SECTORS - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    drac_pkg::drac_state_t state;
    drac_pkg::drac_class_t cls;
    drac_pkg::drac_class_t last_class;
    drac_pkg::drac_lba_t   valid_lo;
    drac_pkg::drac_cnt_t   valid_cnt;
    drac_pkg::drac_ptr_t   base_ptr;
    drac_pkg::drac_lba_t   fetch_lba;
    drac_pkg::drac_ptr_t   disk_side_pointer;
    drac_pkg::drac_lba_t   host_lba;
    drac_pkg::drac_ptr_t   host_side_pointer;
    drac_pkg::drac_lba_t   req_end;
    drac_pkg::drac_lba_t   prev_end;
    drac_pkg::drac_cnt_t   ra_limit;
    logic                  prev_ok;
    logic                  fetch_on;
    logic                  drop_consumed;
    logic                  cache_en_q;
    logic                  xfer_done;

    drac_pkg::drac_lba_t   next_lo;
    drac_pkg::drac_cnt_t   next_cnt;
    drac_pkg::drac_ptr_t   next_base;
    drac_pkg::drac_lba_t   cmd_end;
    drac_pkg::drac_ptr_t   hit_ptr;
    logic                  take;
    logic                  take_read;
    logic                  is_miss;
    logic                  inval;
    logic                  full;
    logic                  need_req;
    logic                  can_drop;
    logic                  med_store;
    logic                  host_take;
    logic                  evict;
    logic                  consume_drop;

    function automatic drac_pkg::drac_ptr_t ptr_inc(input drac_pkg::drac_ptr_t p);
        return (p == LAST_PTR) ? FIRST_PTR : p + 1'b1;
    endfunction

    function automatic drac_pkg::drac_ptr_t ptr_add(input drac_pkg::drac_ptr_t p, input drac_pkg::drac_ptr_t off);
        logic [drac_pkg::PTR_W:0] s;
        s = {1'b0, p} + {1'b0, off};
        if (s > {1'b0, LAST_PTR})
            s = s - CAP_CNT;
        return s[drac_pkg::PTR_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    assign o_cmd_ready = (state == drac_pkg::DRAC_ST_IDLE);
    assign take        = i_cmd_valid && o_cmd_ready;
    assign take_read   = take && (i_cmd.kind == drac_pkg::DRAC_CMD_READ);
    assign inval       = i_soft_reset || i_cmd_error || (cache_en_q && !i_cache_en)
                         || (take && (i_cmd.kind == drac_pkg::DRAC_CMD_OTHER));
    assign is_miss     = (cls == drac_pkg::DRAC_CL_MISS) || (cls == drac_pkg::DRAC_CL_SEQ_MISS);
    assign cmd_end     = drac_pkg::drac_lba_t'(i_cmd.lba + i_cmd.count);
    assign hit_ptr     = ptr_add(base_ptr, drac_pkg::drac_ptr_t'(i_cmd.lba - valid_lo));

    drac_classify u_classify (
        .i_cmd       (i_cmd),
        .i_valid_lo  (valid_lo),
        .i_valid_cnt (valid_cnt),
        .i_prev_end  (prev_end),
        .i_prev_ok   (prev_ok),
        .i_cache_en  (i_cache_en && !inval),
        .o_class     (cls)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Media fetch request
    assign full      = (valid_cnt == CAP_CNT);
    assign need_req  = (state == drac_pkg::DRAC_ST_XFER) && (fetch_lba < req_end);
    assign can_drop  = (valid_lo < host_lba);
    assign o_med_req = fetch_on && (full ? (need_req && can_drop)
                                         : (need_req || (valid_cnt < ra_limit)));
    assign med_store = i_med_done && o_med_req;
    assign evict     = med_store && full;

    ////////////////////////////////////////////////////////////////////////////////
    // Host transfer
    assign o_host_ready = (state == drac_pkg::DRAC_ST_XFER) && (host_lba < fetch_lba)
                          && (host_lba >= valid_lo);
    assign host_take    = i_host_done && o_host_ready;
    assign consume_drop = host_take && drop_consumed && (host_lba == valid_lo) && (valid_cnt != '0);

    ////////////////////////////////////////////////////////////////////////////////
    // Cached window
    always_comb
    begin
        next_lo   = valid_lo;
        next_base = base_ptr;
        next_cnt  = valid_cnt;
        if (evict || consume_drop)
        begin
            next_lo   = valid_lo + 1'b1;
            next_base = ptr_inc(base_ptr);
        end
        if (med_store && !full && !consume_drop)
            next_cnt = valid_cnt + 1'b1;
        else if (consume_drop && !med_store)
            next_cnt = valid_cnt - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            valid_lo  <= drac_pkg::RST_LBA;
            valid_cnt <= drac_pkg::RST_CNT;
            base_ptr  <= FIRST_PTR;
        end
        else if (i_ce)
        begin
            if (take_read && is_miss)
            begin
                valid_lo  <= i_cmd.lba;
                valid_cnt <= drac_pkg::RST_CNT;
                base_ptr  <= disk_side_pointer;
            end
            else if (take_read && (cls == drac_pkg::DRAC_CL_SEQ_HIT) && (last_class == drac_pkg::DRAC_CL_SEQ_HIT))
            begin
                valid_lo  <= i_cmd.lba;
                valid_cnt <= next_cnt - drac_pkg::drac_cnt_t'(i_cmd.lba - valid_lo);
                base_ptr  <= hit_ptr;
            end
            else if (inval)
                valid_cnt <= drac_pkg::RST_CNT;
            else
            begin
                valid_lo  <= next_lo;
                valid_cnt <= next_cnt;
                base_ptr  <= next_base;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Disk side
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fetch_lba         <= drac_pkg::RST_LBA;
            disk_side_pointer <= FIRST_PTR;
            fetch_on          <= 1'b0;
            ra_limit          <= drac_pkg::RST_CNT;
            drop_consumed     <= 1'b0;
        end
        else if (i_ce)
        begin
            if (med_store)
            begin
                fetch_lba         <= fetch_lba + 1'b1;
                disk_side_pointer <= ptr_inc(disk_side_pointer);
            end
            if (take_read)
            begin
                unique case (cls)
                    drac_pkg::DRAC_CL_MISS, drac_pkg::DRAC_CL_SEQ_MISS:
                    begin
                        fetch_lba         <= i_cmd.lba;
                        disk_side_pointer <= disk_side_pointer;
                        fetch_on          <= 1'b1;
                        drop_consumed     <= 1'b0;
                        if (!i_cache_en)
                            ra_limit <= drac_pkg::RST_CNT;
                        else if (cls == drac_pkg::DRAC_CL_MISS)
                            ra_limit <= RA_CNT;
                        else
                            ra_limit <= CAP_CNT;
                    end
                    drac_pkg::DRAC_CL_PARTIAL:
                    begin
                        fetch_on      <= 1'b1;
                        ra_limit      <= RA_CNT;
                        drop_consumed <= 1'b0;
                    end
                    drac_pkg::DRAC_CL_SEQ_HIT:
                    begin
                        fetch_on      <= 1'b1;
                        ra_limit      <= CAP_CNT;
                        drop_consumed <= 1'b1;
                    end
                    drac_pkg::DRAC_CL_FULL:
                    begin
                        drop_consumed <= 1'b0;
                    end
                    default:
                    begin
                        fetch_on <= 1'b0;
                    end
                endcase
            end
            else if (inval)
            begin
                fetch_on      <= 1'b0;
                drop_consumed <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Host side
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state             <= drac_pkg::DRAC_ST_IDLE;
            host_lba          <= drac_pkg::RST_LBA;
            host_side_pointer <= FIRST_PTR;
            req_end           <= drac_pkg::RST_LBA;
            prev_end          <= drac_pkg::RST_LBA;
            prev_ok           <= 1'b0;
            last_class        <= drac_pkg::DRAC_CL_MISS;
            xfer_done         <= 1'b0;
            cache_en_q        <= 1'b0;
        end
        else if (i_ce)
        begin
            cache_en_q <= i_cache_en;
            xfer_done  <= 1'b0;
            if (take_read)
            begin
                state             <= drac_pkg::DRAC_ST_XFER;
                host_lba          <= i_cmd.lba;
                host_side_pointer <= is_miss ? disk_side_pointer : hit_ptr;
                req_end           <= cmd_end;
                prev_end          <= cmd_end;
                prev_ok           <= 1'b1;
                last_class        <= cls;
            end
            else
            begin
                if (inval)
                    prev_ok <= 1'b0;
                unique case (state)
                    drac_pkg::DRAC_ST_IDLE:
                    begin
                    end
                    drac_pkg::DRAC_ST_XFER:
                    begin
                        if (i_cmd_error || i_soft_reset)
                            state <= drac_pkg::DRAC_ST_IDLE;
                        else if (host_take)
                        begin
                            host_lba          <= host_lba + 1'b1;
                            host_side_pointer <= ptr_inc(host_side_pointer);
                            if (drac_pkg::drac_lba_t'(host_lba + 1'b1) == req_end)
                            begin
                                state     <= drac_pkg::DRAC_ST_IDLE;
                                xfer_done <= 1'b1;
                            end
                        end
                    end
                    default:
                    begin
                        state <= drac_pkg::DRAC_ST_IDLE;
                    end
                endcase
            end
        end
    end

    assign o_med        = '{lba: fetch_lba, ptr: disk_side_pointer};
    assign o_host       = '{lba: host_lba, ptr: host_side_pointer};
    assign o_xfer_done  = xfer_done;
    assign o_class      = last_class;
    assign o_cached_cnt = valid_cnt;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking dcb @(posedge i_clk iff i_ce);
    endclocking
    default disable iff (i_rst);

    property p_miss_ptrs;
        take_read && is_miss |=> (host_side_pointer == $past(disk_side_pointer))
                                 && (base_ptr == $past(disk_side_pointer)) && (fetch_lba == host_lba);
    endproperty
    a_miss_ptrs: assert property (p_miss_ptrs) else $error("miss pointers not aligned");

    property p_full_ptr;
        take_read && (cls == drac_pkg::DRAC_CL_FULL) |=> host_side_pointer == $past(hit_ptr);
    endproperty
    a_full_ptr: assert property (p_full_ptr) else $error("full hit pointer wrong");

    property p_full_keep;
        take_read && (cls == drac_pkg::DRAC_CL_FULL) && !inval
        |=> (ra_limit == $past(ra_limit)) && (fetch_on == $past(fetch_on)) && (valid_cnt >= $past(valid_cnt));
    endproperty
    a_full_keep: assert property (p_full_keep) else $error("full hit changed read-ahead");

    property p_full_running;
        take_read && (cls == drac_pkg::DRAC_CL_FULL) && fetch_on |=> fetch_on;
    endproperty
    a_full_running: assert property (p_full_running) else $error("read-ahead halted by full hit");

    property p_inval;
        inval && !take_read |=> (valid_cnt == '0) && !o_med_req ##1 (valid_cnt == '0);
    endproperty
    a_inval: assert property (p_inval) else $error("cache not discarded");

    property p_off_miss;
        !i_cache_en && take_read |-> is_miss;
    endproperty
    a_off_miss: assert property (p_off_miss) else $error("cache served while disabled");

    property p_ra_limit;
        take_read && i_cache_en && !inval && is_miss
        |=> ra_limit == (($past(cls) == drac_pkg::DRAC_CL_MISS) ? RA_CNT : CAP_CNT);
    endproperty
    a_ra_limit: assert property (p_ra_limit) else $error("read-ahead amount wrong");

    property p_seq_drop;
        consume_drop && !take_read && !inval |=> valid_lo == $past(valid_lo) + 1'b1;
    endproperty
    a_seq_drop: assert property (p_seq_drop) else $error("consumed data still cached");

    property p_host_stored;
        o_host_ready |-> (host_lba >= valid_lo) && (host_lba < fetch_lba) && (valid_cnt != '0);
    endproperty
    a_host_stored: assert property (p_host_stored) else $error("host sees unstored sector");

    property p_done;
        host_take && !i_cmd_error && !i_soft_reset && ((host_lba + 1'b1) == req_end)
        |=> o_xfer_done && o_cmd_ready ##1 !o_xfer_done;
    endproperty
    a_done: assert property (p_done) else $error("transfer end not signalled");

    c_miss:    cover property (take_read && (cls == drac_pkg::DRAC_CL_MISS) ##[1:50] o_xfer_done);
    c_seq_hit: cover property (take_read && (cls == drac_pkg::DRAC_CL_SEQ_HIT) ##[1:50] med_store);
    c_full_ra: cover property (take_read && (cls == drac_pkg::DRAC_CL_FULL) && o_med_req);
    c_partial: cover property (take_read && (cls == drac_pkg::DRAC_CL_PARTIAL) ##[1:50] o_xfer_done);
endmodule

/* bench/drac_media_model.sv */
`timescale 1ns/1ps
module drac_media_model (
    input  logic                i_clk,
    input  logic                i_rst,
    input  logic                i_req,
    input  drac_pkg::drac_loc_t i_loc,
    input  logic                i_stall,
    output logic                o_done,
    output int                  o_reads,
    output drac_pkg::drac_lba_t o_last
);
    initial o_done = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // Sector answer, held back while stalled
    always @(negedge i_clk)
        o_done <= i_req && !i_stall && !i_rst && !o_done;
    ////////////////////////////////////////////////////////////////////////
    // Count of fetches and last sector fetched
    always @(posedge i_clk)
    begin
        if (i_rst)
            o_reads <= 0;
        else if (i_req && o_done)
        begin
            o_reads <= o_reads + 1;
            o_last  <= i_loc.lba;
        end
    end
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    localparam int RA = 256;
    logic                  i_clk = 1'b0;
    logic                  i_rst = 1'b1;
    logic                  i_cmd_valid = 1'b0;
    drac_pkg::drac_cmd_t   i_cmd = '0;
    logic                  i_cache_en = 1'b1;
    logic                  i_soft_reset = 1'b0;
    logic                  i_cmd_error = 1'b0;
    logic                  i_host_done = 1'b0;
    logic                  i_med_done;
    logic                  o_cmd_ready, o_med_req, o_host_ready, o_xfer_done;
    drac_pkg::drac_loc_t   o_med, o_host;
    drac_pkg::drac_class_t o_class;
    drac_pkg::drac_cnt_t   o_cached_cnt;
    drac_pkg::drac_lba_t   last, l;
    logic [31:0]           seed = 32'hd489;
    logic [31:0]           rv = 32'h1;
    int                    reads, r0, c;
    int                    errors = 0;
    int                    num_checks = 0;
    always #50 i_clk = ~i_clk;
    drac_cache #(.WORK_SECTORS(512), .RA_SECTORS(RA)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
        .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .i_cache_en(i_cache_en),
        .i_soft_reset(i_soft_reset), .i_cmd_error(i_cmd_error), .o_med_req(o_med_req), .o_med(o_med),
        .i_med_done(i_med_done), .o_host_ready(o_host_ready), .o_host(o_host), .i_host_done(i_host_done),
        .o_xfer_done(o_xfer_done), .o_class(o_class), .o_cached_cnt(o_cached_cnt));
    drac_media_model media (.i_clk(i_clk), .i_rst(i_rst), .i_req(o_med_req), .i_loc(o_med),
        .i_stall(rv[0]), .o_done(i_med_done), .o_reads(reads), .o_last(last));
    ////////////////////////////////////////////////////////////////////////
    // Random source
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    always @(negedge i_clk)
    begin
        seed = xorshift(seed);
        rv <= seed;
    end
    ////////////////////////////////////////////////////////////////////////
    // Checking and ending
    task report_and_stop;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n, input int lim);
        if (n >= lim)
        begin
            chk(40'(n), 40'(0));
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Host side transfers and waits on media fetches
    task automatic issue(input drac_pkg::drac_kind_t k, input drac_pkg::drac_lba_t a, input int n);
        int w = 0;
        while (o_cmd_ready !== 1'b1 && w < 100)
        begin
            @(negedge i_clk);
            w++;
        end
        bound(w, 100);
        i_cmd = '{kind: k, lba: a, count: n[8:0]};
        i_cmd_valid = 1'b1;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
    endtask
    task automatic do_read(input drac_pkg::drac_lba_t a, input int n, input drac_pkg::drac_class_t cl);
        int w;
        issue(drac_pkg::DRAC_CMD_READ, a, n);
        chk(40'(o_class), 40'(cl));
        for (int i = 0; i < n; i++)
        begin
            w = 0;
            while (o_host_ready !== 1'b1 && w < 20000)
            begin
                @(negedge i_clk);
                w++;
            end
            bound(w, 20000);
            chk(40'(o_host.lba), 40'(a + drac_pkg::drac_lba_t'(i)));
            i_host_done = 1'b1;
            @(negedge i_clk);
            i_host_done = 1'b0;
            if (rv[2] && i + 1 < n)
                @(negedge i_clk);
        end
        w = 0;
        while (o_xfer_done !== 1'b1 && w < 3)
        begin
            @(negedge i_clk);
            w++;
        end
        chk(40'(o_xfer_done), 40'(1));
    endtask
    task automatic wait_fill;
        int w = 0;
        repeat (2) @(negedge i_clk);
        while ((o_med_req !== 1'b0 || o_cmd_ready !== 1'b1) && w < 30000)
        begin
            @(negedge i_clk);
            w++;
        end
        bound(w, 30000);
    endtask
    task automatic wait_fetch(input drac_pkg::drac_lba_t a);
        int w = 0;
        while (o_med.lba < a && w < 5000)
        begin
            @(negedge i_clk);
            w++;
        end
        bound(w, 5000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        chk(40'(o_cached_cnt), 40'(0));
        chk(40'(o_host.ptr), 40'(512));
        $display("test reset done");
        do_read(28'd10, 2, drac_pkg::DRAC_CL_MISS);
        wait_fill();
        chk(40'(o_cached_cnt), 40'(RA));
        chk(40'(last), 40'(10 + RA - 1));
        r0 = reads;
        do_read(28'd20, 4, drac_pkg::DRAC_CL_FULL);
        wait_fill();
        chk(40'(reads - r0), 40'(0));
        chk(40'(o_cached_cnt), 40'(RA));
        do_read(28'd24, 256, drac_pkg::DRAC_CL_SEQ_HIT);
        wait_fill();
        chk(40'(o_cached_cnt), 40'(4096 - 512));
        $display("test hits done");
        issue(drac_pkg::DRAC_CMD_WRITE, 28'd0, 1);
        issue(drac_pkg::DRAC_CMD_CHKPWR, 28'd0, 1);
        @(negedge i_clk);
        chk(40'(o_cached_cnt), 40'(4096 - 512));
        issue(drac_pkg::DRAC_CMD_OTHER, 28'd0, 1);
        @(negedge i_clk);
        chk(40'(o_cached_cnt), 40'(0));
        for (int s = 0; s < 4; s++)
        begin
            l = drac_pkg::drac_lba_t'(rv[26:0] | 27'h0100000);
            c = 1 + int'(rv[7:4]);
            do_read(l, c, drac_pkg::DRAC_CL_MISS);
            wait_fill();
            chk(40'(last), 40'(l + RA - 1));
            case (s)
                0: issue(drac_pkg::DRAC_CMD_OTHER, 28'd0, 1);
                1: i_cmd_error = 1'b1;
                2: i_soft_reset = 1'b1;
                default: i_cache_en = 1'b0;
            endcase
            @(negedge i_clk);
            i_cmd_error = 1'b0;
            i_soft_reset = 1'b0;
            @(negedge i_clk);
            chk(40'(o_cached_cnt), 40'(0));
            i_cache_en = 1'b1;
        end
        $display("test invalidate done");
        do_read(28'd1000, 1, drac_pkg::DRAC_CL_MISS);
        wait_fill();
        do_read(28'd1250, 20, drac_pkg::DRAC_CL_PARTIAL);
        wait_fill();
        $display("test partial done");
        do_read(28'd1270, 4, drac_pkg::DRAC_CL_SEQ_MISS);
        wait_fetch(28'd1290);
        do_read(28'd1280, 4, drac_pkg::DRAC_CL_FULL);
        chk(40'(o_med_req), 40'(1));
        do_read(28'd1284, 256, drac_pkg::DRAC_CL_SEQ_HIT);
        wait_fetch(28'd1550);
        do_read(28'd1540, 256, drac_pkg::DRAC_CL_SEQ_HIT);
        wait_fill();
        chk(40'(o_med.lba), 40'(1796 + 3584));
        chk(40'(o_cached_cnt), 40'(4096 - 512));
        $display("test sequential done");
        i_cache_en = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            r0 = reads;
            do_read(28'd5000, 3, drac_pkg::DRAC_CL_MISS);
            wait_fill();
            chk(40'(reads - r0), 40'(3));
        end
        $display("test cache off done");
        report_and_stop();
    end
endmodule
